// ### logic/lbpq_cfg.svh
// Constants of the learning bridge and priority queue block.
`ifndef LBPQ_CFG_SVH
`define LBPQ_CFG_SVH
`define LBPQ_ENTRIES 500
`define LBPQ_IDXW 9
`define LBPQ_LAST_IDX 9'h1F3
`define LBPQ_NREM 4
`define LBPQ_RIDW 2
`define LBPQ_TAGW 16
`define LBPQ_NPRIO 4
`define LBPQ_FIFO_DEPTH 16
`define LBPQ_BCAST 48'hFFFF_FFFF_FFFF
`define LBPQ_PREC_HIGH 3'h6
`define LBPQ_USE_MAX 8'hFF
`define LBPQ_CLK_NS 20
`define LBPQ_TICK_NS 1000000000
`endif

// ### logic/lbpq_pkg.sv
// Types shared by the learning bridge and priority queue block.
package lbpq_pkg;
	typedef logic [47:0] lbpq_mac_t;
	typedef enum logic [1:0] {
		PRIO_VITAL   = 2'h0,
		PRIO_GATEWAY = 2'h1,
		PRIO_HIGH    = 2'h2,
		PRIO_LOW     = 2'h3
	} lbpq_prio_t;
endpackage

// ### logic/lbpq_bridge.sv
// Learning bridge with address table and strict-priority radio queues.
`timescale 1ns/1ns
`include "lbpq_cfg.svh"

// ****************************************************************
// Queue storage
// ****************************************************************
module lbpq_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             mclk,
	input  wire logic             rstSync_b,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  spare,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_q;
	logic [AW-1:0]    rdPtr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;

	// Handshakes on both sides; spare leaves room for two frames in flight.
	assign inReady  = count_q != (AW+1)'(DEPTH);
	assign outValid = count_q != '0;
	assign spare    = count_q <= (AW+1)'(DEPTH - 3);
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;
	assign outData  = mem[rdPtr_q];

	// Pointers and level.
	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			wrPtr_q <= wrPtr_q + AW'(push);
			rdPtr_q <= rdPtr_q + AW'(pop);
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Data is not reset; only valid words are ever popped.
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end
endmodule

// ****************************************************************
// Bridge top
// ****************************************************************
module lbpq_bridge #(
	parameter int TICK_CYCLES = `LBPQ_TICK_NS / `LBPQ_CLK_NS
) (
	input  wire logic                  mclk,
	input  wire logic                  rst_b,
	input  wire logic [15:0]           ageTimeout,
	input  wire logic [15:0]           vitalPort,
	input  wire logic                  lanValid,
	output logic                       lanReady,
	input  wire lbpq_pkg::lbpq_mac_t   lanDst,
	input  wire lbpq_pkg::lbpq_mac_t   lanSrc,
	input  wire logic [`LBPQ_TAGW-1:0] lanTag,
	input  wire logic                  lanUdp,
	input  wire logic [15:0]           lanUdpPort,
	input  wire logic                  lanGwSerial,
	input  wire logic                  lanMgmt,
	input  wire logic                  lanIp,
	input  wire logic [7:0]            lanTos,
	input  wire logic                  rfValid,
	output logic                       rfReady,
	input  wire lbpq_pkg::lbpq_mac_t   rfSrc,
	input  wire logic [`LBPQ_RIDW-1:0] rfRemote,
	input  wire logic                  txReq,
	output logic                       txValid,
	output logic [`LBPQ_TAGW-1:0]      txTag,
	output logic [`LBPQ_NREM-1:0]      txMask,
	output lbpq_pkg::lbpq_prio_t       txPrio
);
	localparam int DW = `LBPQ_TAGW + `LBPQ_NREM;
	localparam int N  = `LBPQ_ENTRIES;

	// Lowest set index of a table-wide vector.
	function automatic logic [`LBPQ_IDXW-1:0] lbpqFirst(input logic [N-1:0] v);
		logic [`LBPQ_IDXW-1:0] r;
		r = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = `LBPQ_IDXW'(i);
			end
		end
		return r;
	endfunction

	// ************************************************************
	// Reset release and time base
	// ************************************************************
	logic        rstMeta_b;
	logic        rstSync_b;
	logic [31:0] tickCnt_q;
	logic [15:0] epoch_q;

	// Release is synchronised so all flops leave reset on one edge.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_b <= 1'b0;
			rstSync_b <= 1'b0;
		end else begin
			rstMeta_b <= 1'b1;
			rstSync_b <= rstMeta_b;
		end
	end

	// The age epoch advances once per tick, so entries store a stamp only.
	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			tickCnt_q <= '0;
			epoch_q   <= '0;
		end else if (tickCnt_q == 32'(TICK_CYCLES - 1)) begin
			tickCnt_q <= '0;
			epoch_q   <= epoch_q + 16'h0001;
		end else begin
			tickCnt_q <= tickCnt_q + 32'h0000_0001;
		end
	end

	// ************************************************************
	// Address table
	// ************************************************************
	lbpq_pkg::lbpq_mac_t   entMac [N];
	logic                  entValid [N];
	logic                  entRem [N];
	logic [`LBPQ_RIDW-1:0] entRid [N];
	logic [7:0]            entUse [N];
	logic [15:0]           entStamp [N];
	logic [N-1:0]          srcVec;
	logic [N-1:0]          dstVec;
	logic [N-1:0]          freeVec;
	logic                  phase_q;
	logic                  lanReady_q;
	logic                  rfReady_q;
	logic                  lanTake;
	logic                  rfTake;
	logic                  learnDo;
	lbpq_pkg::lbpq_mac_t   learnMac;
	logic [`LBPQ_IDXW-1:0] srcIdx;
	logic [`LBPQ_IDXW-1:0] dstIdx;
	logic [`LBPQ_IDXW-1:0] wrIdx;
	logic                  srcHit;
	logic                  dstHit;
	logic [`LBPQ_IDXW-1:0] scanPtr_q;
	logic [`LBPQ_IDXW-1:0] candIdx_q;
	logic [7:0]            candUse_q;
	logic [`LBPQ_IDXW-1:0] victimIdx_q;
	logic                  scanExp;
	logic [`LBPQ_NPRIO-1:0] fifoSpare;

	// LAN and radio learning take alternate cycles, one table write each.
	assign lanTake  = lanValid && lanReady_q;
	assign rfTake   = rfValid && rfReady_q;
	assign learnDo  = lanTake || rfTake;
	assign learnMac = lanTake ? lanSrc : rfSrc;
	assign srcHit   = |srcVec;
	assign dstHit   = |dstVec;
	assign srcIdx   = lbpqFirst(srcVec);
	assign dstIdx   = lbpqFirst(dstVec);
	assign wrIdx    = srcHit ? srcIdx : (|freeVec ? lbpqFirst(freeVec) : victimIdx_q);
	assign scanExp  = entValid[scanPtr_q] && ((epoch_q - entStamp[scanPtr_q]) > ageTimeout);

	for (genvar i = 0; i < N; i++) begin : gEnt
		assign srcVec[i]  = entValid[i] && (entMac[i] == learnMac);
		assign dstVec[i]  = entValid[i] && (entMac[i] == lanDst);
		assign freeVec[i] = !entValid[i];
		always_ff @(posedge mclk or negedge rstSync_b) begin
			if (!rstSync_b) begin
				entValid[i] <= 1'b0;
				entMac[i]   <= '0;
				entRem[i]   <= 1'b0;
				entRid[i]   <= '0;
				entUse[i]   <= '0;
				entStamp[i] <= '0;
			end else if (learnDo && wrIdx == `LBPQ_IDXW'(i)) begin
				entValid[i] <= 1'b1;
				entMac[i]   <= learnMac;
				entRem[i]   <= rfTake;
				entRid[i]   <= rfRemote;
				entStamp[i] <= epoch_q;
				entUse[i]   <= srcHit ? entUse[i] + 8'(entUse[i] != `LBPQ_USE_MAX) : 8'h01;
			end else if (lanTake && dstHit && dstIdx == `LBPQ_IDXW'(i)) begin
				entStamp[i] <= epoch_q;
				entUse[i]   <= entUse[i] + 8'(entUse[i] != `LBPQ_USE_MAX);
			end else if (scanExp && scanPtr_q == `LBPQ_IDXW'(i)) begin
				entValid[i] <= 1'b0;
			end
		end
	end

	// A sweep visits one entry a cycle; the victim is the minimum of entries 0 to 498, the comparison of the last entry is never latched.
	// The victim may be one sweep stale, which only bends the ranking.
	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			scanPtr_q   <= '0;
			candIdx_q   <= '0;
			candUse_q   <= `LBPQ_USE_MAX;
			victimIdx_q <= '0;
		end else begin
			scanPtr_q <= (scanPtr_q == `LBPQ_LAST_IDX) ? '0 : scanPtr_q + 9'h001;
			if (scanPtr_q == '0 || entUse[scanPtr_q] < candUse_q) begin
				candIdx_q <= scanPtr_q;
				candUse_q <= entUse[scanPtr_q];
			end
			if (scanPtr_q == `LBPQ_LAST_IDX) begin
				victimIdx_q <= candIdx_q;
			end
		end
	end

	// Ready flops alternate and hold off LAN frames when any queue is low.
	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			phase_q    <= 1'b0;
			lanReady_q <= 1'b0;
			rfReady_q  <= 1'b0;
		end else begin
			phase_q    <= !phase_q;
			lanReady_q <= phase_q && (&fifoSpare);
			rfReady_q  <= !phase_q;
		end
	end

	// ************************************************************
	// Forwarding decision and classification
	// ************************************************************
	logic                   isBcast;
	logic                   dropLocal;
	logic [`LBPQ_NREM-1:0]  fwdMask;
	logic                   isVital;
	logic                   precHigh;
	lbpq_pkg::lbpq_prio_t   cls;
	logic                   stValid_q;
	lbpq_pkg::lbpq_prio_t   stPrio_q;
	logic [DW-1:0]          stData_q;

	assign isBcast   = lanDst == `LBPQ_BCAST;
	assign dropLocal = !isBcast && dstHit && !entRem[dstIdx];
	assign fwdMask   = (!isBcast && dstHit) ? `LBPQ_NREM'(1) << entRid[dstIdx] : '1;
	assign isVital   = lanUdp && (lanUdpPort == vitalPort);
	// codepoint precedence; precedence 6 or 7
	assign precHigh  = lanIp && (lanTos[4:2] == 3'h0) && (lanTos[7:5] >= `LBPQ_PREC_HIGH);
	// class order; gateway second; management high
	assign cls = isVital ? lbpq_pkg::PRIO_VITAL :
		lanGwSerial ? lbpq_pkg::PRIO_GATEWAY :
		(lanMgmt || precHigh) ? lbpq_pkg::PRIO_HIGH : lbpq_pkg::PRIO_LOW;

	// Frame descriptor waits one cycle here before entering its queue.
	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			stValid_q <= 1'b0;
			stPrio_q  <= lbpq_pkg::PRIO_LOW;
			stData_q  <= '0;
		end else begin
			stValid_q <= lanTake && !dropLocal;
			stPrio_q  <= cls;
			stData_q  <= {fwdMask, lanTag};
		end
	end

	// ************************************************************
	// Priority queues and radio service
	// ************************************************************
	logic [`LBPQ_NPRIO-1:0] fifoInReady;
	logic [`LBPQ_NPRIO-1:0] fifoOutValid;
	logic [`LBPQ_NPRIO-1:0] popVec;
	logic [DW-1:0]          fifoOut [`LBPQ_NPRIO];
	logic [1:0]             popSel;
	logic                   txTake;
	logic                   txValid_q;
	logic [DW-1:0]          txData_q;
	lbpq_pkg::lbpq_prio_t   txPrio_q;

	for (genvar p = 0; p < `LBPQ_NPRIO; p++) begin : gQue
		assign popVec[p] = txTake && (popSel == 2'(p));
		lbpq_fifo #(.WIDTH(DW), .DEPTH(`LBPQ_FIFO_DEPTH)) uFifo (
			.mclk     (mclk),
			.rstSync_b(rstSync_b),
			.inValid  (stValid_q && (stPrio_q == lbpq_pkg::lbpq_prio_t'(p))),
			.inReady  (fifoInReady[p]),
			.inData   (stData_q),
			.spare    (fifoSpare[p]),
			.outValid (fifoOutValid[p]),
			.outReady (popVec[p]),
			.outData  (fifoOut[p])
		);
	end

	assign popSel = fifoOutValid[0] ? 2'h0 : fifoOutValid[1] ? 2'h1 :
		fifoOutValid[2] ? 2'h2 : 2'h3;
	assign txTake = txReq && (|fifoOutValid);

	// One frame leaves per transmit opportunity.
	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			txValid_q <= 1'b0;
			txData_q  <= '0;
			txPrio_q  <= lbpq_pkg::PRIO_LOW;
		end else begin
			txValid_q <= txTake;
			txData_q  <= fifoOut[popSel];
			txPrio_q  <= lbpq_pkg::lbpq_prio_t'(popSel);
		end
	end

	assign lanReady = lanReady_q;
	assign rfReady  = rfReady_q;
	assign txValid  = txValid_q;
	assign txTag    = txData_q[`LBPQ_TAGW-1:0];
	assign txMask   = txData_q[DW-1:`LBPQ_TAGW];
	assign txPrio   = txPrio_q;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstSync_b);

	sequence sFlood;
		lanTake && (isBcast || !dstHit);
	endsequence
	sequence sQueued;
		stValid_q && (stData_q[DW-1:`LBPQ_TAGW] == '1);
	endsequence

	AST_LEARN_LOCAL: assert property (lanTake |=> entValid[$past(wrIdx)] && !entRem[$past(wrIdx)])
		else $error("LAN source not learned as local.");
	AST_LEARN_RF: assert property (rfTake |=> entRem[$past(wrIdx)] && entRid[$past(wrIdx)] == $past(rfRemote))
		else $error("Radio source not learned with its remote.");
	AST_DROP_LOCAL: assert property (lanTake && dropLocal |=> !stValid_q)
		else $error("Local destination frame was forwarded.");
	AST_UNICAST: assert property (lanTake && !isBcast && dstHit && entRem[dstIdx] |=> stValid_q && $onehot(stData_q[DW-1:`LBPQ_TAGW]))
		else $error("Known remote frame not sent to one remote.");
	AST_FLOOD: assert property (sFlood |=> sQueued)
		else $error("Unknown or broadcast frame not flooded.");
	AST_VITAL: assert property (lanTake && !dropLocal && isVital |=> stPrio_q == lbpq_pkg::PRIO_VITAL)
		else $error("Vital frame not in top queue.");
	AST_TOS_HIGH: assert property (lanTake && !dropLocal && !isVital && !lanGwSerial && lanIp && lanTos == 8'hE0 |=> stPrio_q == lbpq_pkg::PRIO_HIGH)
		else $error("Precedence 7 frame not high priority.");
	AST_NO_OVERFLOW: assert property (stValid_q |-> fifoInReady[stPrio_q])
		else $error("Queue written while full.");
	AST_STRICT: assert property (txReq && fifoOutValid[0] |=> txValid_q && txPrio_q == lbpq_pkg::PRIO_VITAL)
		else $error("Vital queue not served first.");
endmodule

// ### test/lbpq_lan_model.sv
// Partner model of the LAN stations and remote radios feeding the bridge.
`timescale 1ns/1ns
`include "lbpq_cfg.svh"

module lbpq_lan_model (
	input  wire logic		mclk,
	input  wire logic		lanReady,
	input  wire logic		rfReady,
	output logic			lanValid,
	output lbpq_pkg::lbpq_mac_t	lanDst,
	output lbpq_pkg::lbpq_mac_t	lanSrc,
	output logic [`LBPQ_TAGW-1:0]	lanTag,
	output logic			lanUdp,
	output logic [15:0]		lanUdpPort,
	output logic			lanGwSerial,
	output logic			lanMgmt,
	output logic			lanIp,
	output logic [7:0]		lanTos,
	output logic			rfValid,
	output lbpq_pkg::lbpq_mac_t	rfSrc,
	output logic [`LBPQ_RIDW-1:0]	rfRemote
);
	// Requests that ready never took within the limit; a hang must not pass.
	int				stallCount = 0;

	// Quiet at time zero.
	initial begin
		{lanValid, lanUdp, lanGwSerial, lanMgmt, lanIp, rfValid} = 6'h00;
		{lanDst, lanSrc, rfSrc} = 144'h0;
		{lanTag, lanUdpPort, lanTos, rfRemote} = 42'h0;
	end

	// A descriptor is held until an edge with ready high takes it; after
	// release the data lines show the inverse so stale values never match.
	task automatic sendLan(input lbpq_pkg::lbpq_mac_t dst, input lbpq_pkg::lbpq_mac_t src,
		input logic [15:0] tag, input logic [15:0] port, input logic [3:0] fl,
		input logic [7:0] tos);
		int n = 0;
		@(negedge mclk);
		{lanDst, lanSrc, lanTag, lanUdpPort, lanTos} = {dst, src, tag, port, tos};
		{lanUdp, lanGwSerial, lanMgmt, lanIp, lanValid} = {fl, 1'b1};
		while (lanReady !== 1'b1 && n < 64) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 64) begin
			stallCount++;
		end
		@(negedge mclk);
		lanValid = 1'b0;
		{lanDst, lanSrc, lanTag, lanUdpPort, lanTos} = ~{dst, src, tag, port, tos};
	endtask

	// A radio source learn, held the same way.
	task automatic learnRf(input lbpq_pkg::lbpq_mac_t src, input logic [1:0] rid);
		int n = 0;
		@(negedge mclk);
		{rfSrc, rfRemote, rfValid} = {src, rid, 1'b1};
		while (rfReady !== 1'b1 && n < 64) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 64) begin
			stallCount++;
		end
		@(negedge mclk);
		rfValid = 1'b0;
		{rfSrc, rfRemote} = ~{src, rid};
	endtask
endmodule

// ### test/learning_bridge_priority_queue_test.sv
// Self-checking testbench of the learning bridge with priority queues.
`timescale 1ns/1ns
`include "lbpq_cfg.svh"

module learning_bridge_priority_queue_test;
	localparam lbpq_pkg::lbpq_mac_t ML = 48'h0200_0000_0001;
	localparam lbpq_pkg::lbpq_mac_t MU = 48'h0200_0000_1000;
	localparam lbpq_pkg::lbpq_mac_t MA = 48'h0200_0000_00A0;
	localparam lbpq_pkg::lbpq_mac_t MB = 48'h0200_0000_00B0;
	localparam lbpq_pkg::lbpq_mac_t MH = 48'h0200_0000_00C0;
	localparam lbpq_pkg::lbpq_mac_t MN = 48'h0200_0000_00D0;
	localparam lbpq_pkg::lbpq_mac_t MF = 48'h0200_0001_0000;
	logic			mclk;
	logic			rst_b;
	logic [15:0]		ageTimeout;
	logic [15:0]		vitalPort;
	logic			txReq;
	logic			lanValid, lanReady, lanUdp, lanGwSerial, lanMgmt, lanIp;
	logic			rfValid, rfReady, txValid;
	lbpq_pkg::lbpq_mac_t	lanDst, lanSrc, rfSrc;
	logic [15:0]		lanTag, lanUdpPort, txTag;
	logic [7:0]		lanTos;
	logic [1:0]		rfRemote;
	logic [3:0]		txMask;
	lbpq_pkg::lbpq_prio_t	txPrio;
	int			err_count = 0;
	int			cmp_count = 0;

	lbpq_bridge #(.TICK_CYCLES(8)) lbpq_bridge_i (.mclk(mclk), .rst_b(rst_b),
		.ageTimeout(ageTimeout), .vitalPort(vitalPort), .lanValid(lanValid),
		.lanReady(lanReady), .lanDst(lanDst), .lanSrc(lanSrc), .lanTag(lanTag),
		.lanUdp(lanUdp), .lanUdpPort(lanUdpPort), .lanGwSerial(lanGwSerial),
		.lanMgmt(lanMgmt), .lanIp(lanIp), .lanTos(lanTos), .rfValid(rfValid),
		.rfReady(rfReady), .rfSrc(rfSrc), .rfRemote(rfRemote), .txReq(txReq),
		.txValid(txValid), .txTag(txTag), .txMask(txMask), .txPrio(txPrio));

	lbpq_lan_model lbpq_lan_model_i (.mclk(mclk), .lanReady(lanReady), .rfReady(rfReady),
		.lanValid(lanValid), .lanDst(lanDst), .lanSrc(lanSrc), .lanTag(lanTag),
		.lanUdp(lanUdp), .lanUdpPort(lanUdpPort), .lanGwSerial(lanGwSerial),
		.lanMgmt(lanMgmt), .lanIp(lanIp), .lanTos(lanTos), .rfValid(rfValid),
		.rfSrc(rfSrc), .rfRemote(rfRemote));

	// Free-running 50 MHz clock.
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report;
		if (err_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Reset for 12 cycles; outputs are looked at while it is held.
	task automatic doReset;
		@(negedge mclk);
		rst_b = 1'b0;
		repeat (6) @(negedge mclk);
		check("rstPrio", txPrio, 2'h3);
		check("rstValid", {txValid, lanReady, rfReady}, 3'h0);
		repeat (6) @(negedge mclk);
		rst_b = 1'b1;
		repeat (4) @(negedge mclk);
	endtask

	// One transmit opportunity; the answer stands one cycle after the take.
	task automatic popTx(input logic v, input logic [15:0] tag, input logic [3:0] mask,
		input logic [1:0] prio);
		repeat (2) @(negedge mclk);
		txReq = 1'b1;
		@(negedge mclk);
		check("txValid", txValid, v);
		if (v) begin
			check("txTag", txTag, tag);
			check("txMask", txMask, mask);
			check("txPrio", txPrio, prio);
		end
		txReq = 1'b0;
	endtask

	// A plain low-priority frame from the local station, then one pop.
	task automatic fwd(input lbpq_pkg::lbpq_mac_t dst, input logic [15:0] tag,
		input logic v, input logic [3:0] mask);
		lbpq_lan_model_i.sendLan(dst, ML, tag, 16'h0000, 4'h0, 8'h00);
		popTx(v, tag, mask, 2'h3);
	endtask

	task automatic testPrio;
		logic [35:0] ord = 36'h432671589;
		logic [17:0] pri = 18'h06AFF;
		lbpq_lan_model_i.sendLan(MU + 48'h1, ML, 16'h1, 16'h0000, 4'h0, 8'h00);
		lbpq_lan_model_i.sendLan(MU + 48'h2, ML, 16'h2, 16'h0000, 4'h1, 8'hE0);
		lbpq_lan_model_i.sendLan(MU + 48'h3, ML, 16'h3, 16'h0000, 4'h4, 8'h00);
		lbpq_lan_model_i.sendLan(MU + 48'h4, ML, 16'h4, 16'h1F90, 4'h8, 8'h00);
		lbpq_lan_model_i.sendLan(MU + 48'h5, ML, 16'h5, 16'h1F91, 4'h8, 8'h00);
		lbpq_lan_model_i.sendLan(MU + 48'h6, ML, 16'h6, 16'h0000, 4'h2, 8'h00);
		lbpq_lan_model_i.sendLan(MU + 48'h7, ML, 16'h7, 16'h0000, 4'h1, 8'hC0);
		lbpq_lan_model_i.sendLan(MU + 48'h8, ML, 16'h8, 16'h0000, 4'h1, 8'hE4);
		lbpq_lan_model_i.sendLan(MU + 48'h9, ML, 16'h9, 16'h0000, 4'h1, 8'hA0);
		for (int i = 0; i < 9; i++) begin
			popTx(1'b1, {12'h000, ord[35-4*i -: 4]}, 4'hF, pri[17-2*i -: 2]);
		end
		popTx(1'b0, 16'h0, 4'h0, 2'h0);
	endtask

	task automatic testLearn;
		lbpq_lan_model_i.learnRf(MA, 2'h2);
		fwd(MA, 16'h0011, 1'b1, 4'h4);
		fwd(ML, 16'h0012, 1'b0, 4'h0);
		fwd(`LBPQ_BCAST, 16'h0013, 1'b1, 4'hF);
	endtask

	task automatic testAge;
		ageTimeout = 16'h0002;
		lbpq_lan_model_i.learnRf(MB, 2'h1);
		fwd(MB, 16'h0021, 1'b1, 4'h2);
		repeat (800) @(negedge mclk);
		fwd(MB, 16'h0022, 1'b1, 4'hF);
		ageTimeout = 16'hFFFF;
	endtask

	// a full table keeps its busy entry when it evicts.
	task automatic testEvict;
		doReset;
		fwd(MH, 16'h0031, 1'b1, 4'hF);
		repeat (10) lbpq_lan_model_i.learnRf(MH, 2'h1);
		for (int k = 0; k < 498; k++) begin
			lbpq_lan_model_i.learnRf(MF + 48'(k), 2'h3);
		end
		fwd(MF + 48'h1F1, 16'h0032, 1'b1, 4'h8);
		repeat (1000) @(negedge mclk);
		lbpq_lan_model_i.learnRf(MN, 2'h0);
		fwd(MN, 16'h0033, 1'b1, 4'h1);
		fwd(MH, 16'h0034, 1'b1, 4'h2);
	endtask

	// Main sequence.
	initial begin
		rst_b = 1'b0;
		txReq = 1'b0;
		ageTimeout = 16'hFFFF;
		vitalPort = 16'h1F90;
		doReset;
		testPrio;
		testLearn;
		testAge;
		testEvict;
		check("stallCount", lbpq_lan_model_i.stallCount, 64'h0);
		final_report;
	end

	// Cuts a hang short; the tests need well under 10000 cycles.
	initial begin
		#(20 * 40000);
		err_count++;
		final_report;
	end
endmodule
